//--- rtl/periph_irq_flag_regs.sv
// peripheral request flag registers 11 to 14
`timescale 1ns/1ps
`default_nettype none
`include "irq_flag_defines.svh"
module periph_irq_flag_regs
    import irq_flag_pkg::*;
(
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // register port
    input  wire logic [11:0]  addr,
    input  wire logic [7:0]   wdata,
    input  wire logic         wr_strobe,
    input  wire logic         rd_strobe,
    output logic      [7:0]   rdata,
    // dma event pulses
    input  wire dma_events_t  dma_ch4_events,
    input  wire dma_events_t  dma_ch5_events,
    input  wire dma_events_t  dma_ch6_events,
    // other peripheral event pulses
    input  wire logic         timer_four_event,
    input  wire logic         waveform_gen_three_event,
    input  wire logic         logic_cell_six_event,
    input  wire logic         capture_compare_three_event,
    input  wire logic         num_osc_three_event,
    input  wire logic         comparator_two_event,
    input  wire logic         logic_cell_seven_event,
    // uart state
    input  wire uart_status_t uart_four_status,
    input  wire uart_status_t uart_five_status,
    // flag state
    output logic      [7:0]   periph_irq_flags_11,
    output logic      [7:0]   periph_irq_flags_12,
    output logic      [7:0]   periph_irq_flags_13,
    output logic      [7:0]   periph_irq_flags_14
);
    // ****************************************
    // address decode
    // ****************************************
    logic wr11, wr12, wr13, wr14;
    always_comb begin
        wr11 = 1'b0;
        wr12 = 1'b0;
        wr13 = 1'b0;
        wr14 = 1'b0;
        if (wr_strobe && addr == `OFS_FLAGS_11) begin
            wr11 = 1'b1;
        end else if (wr_strobe && addr == `OFS_FLAGS_12) begin
            wr12 = 1'b1;
        end else if (wr_strobe && addr == `OFS_FLAGS_13) begin
            wr13 = 1'b1;
        end else if (wr_strobe && addr == `OFS_FLAGS_14) begin
            wr14 = 1'b1;
        end
    end

    // ****************************************
    // sticky flags
    // ****************************************
    logic [7:0] sticky11, sticky12, sticky13, sticky14;

    sticky_flag_bank #(.WIDTH(8), .MASK(`STICKY_MASK_11)) u_bank11 (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .set_event ({dma_ch4_events, timer_four_event, waveform_gen_three_event,
                     logic_cell_six_event, capture_compare_three_event}), // R14 R15
        .wr        (wr11),
        .wdata     (wdata),
        .flags     (sticky11)
    );
    sticky_flag_bank #(.WIDTH(8), .MASK(`STICKY_MASK_12)) u_bank12 (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .set_event ({dma_ch5_events, 4'h0}), // R4
        .wr        (wr12),
        .wdata     (wdata),
        .flags     (sticky12)
    );
    sticky_flag_bank #(.WIDTH(8), .MASK(`STICKY_MASK_13)) u_bank13 (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .set_event ({dma_ch6_events, 4'h0}), // R9
        .wr        (wr13),
        .wdata     (wdata),
        .flags     (sticky13)
    );
    sticky_flag_bank #(.WIDTH(8), .MASK(`STICKY_MASK_14)) u_bank14 (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .set_event ({4'h0, num_osc_three_event, comparator_two_event,
                     logic_cell_seven_event, 1'b0}), // R13
        .wr        (wr14),
        .wdata     (wdata),
        .flags     (sticky14)
    );

    // ****************************************
    // uart mirror flags, never written by software
    // ****************************************
    logic [3:0] uart_four_mirror, uart_five_mirror;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            uart_four_mirror <= 4'h0; // R5
        end else begin
            uart_four_mirror <= uart_four_status; // R6 R7 R8
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            uart_five_mirror <= 4'h0;
        end else begin
            uart_five_mirror <= uart_five_status; // R10 R11 R12
        end
    end

    assign periph_irq_flags_11 = sticky11;
    assign periph_irq_flags_12 = {sticky12[7:4], uart_four_mirror};
    assign periph_irq_flags_13 = {sticky13[7:4], uart_five_mirror};
    assign periph_irq_flags_14 = sticky14;

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= `READ_ZERO;
        end else if (!rd_strobe) begin
            rdata <= `READ_ZERO;
        end else if (addr == `OFS_FLAGS_11) begin
            rdata <= periph_irq_flags_11;
        end else if (addr == `OFS_FLAGS_12) begin
            rdata <= periph_irq_flags_12;
        end else if (addr == `OFS_FLAGS_13) begin
            rdata <= periph_irq_flags_13;
        end else if (addr == `OFS_FLAGS_14) begin
            rdata <= periph_irq_flags_14;
        end else begin
            rdata <= `READ_ZERO;
        end
    end
endmodule : periph_irq_flag_regs
`default_nettype wire

//--- common/irq_flag_defines.svh
// offsets, bit positions and reset values of the peripheral request flag bank
// Functional notes
// R1: flags set by source regardless of enables
// R2: software clears flags before enabling sources
// R3: one means event seen, zero none
// R4: reg12 bits 7-4 dma5 sticky flags
// R5: reg12 bits 3-0 uart4 read-only mirrors
// R6: uart4 summary drops when general reg clear
// R7: uart4 error drops when error reg clear
// R8: uart4 tx/rx follow uart, unwritable
// R9: reg13 bits 7-4 dma6 sticky flags
// R10: reg13 bit3 uart5 summary, read-only
// R11: reg13 bit2 uart5 error, read-only
// R12: uart5 tx/rx read-only, unwritable
// R13: reg14 bits 3-1 osc, comparator, cell7
// R14: reg11 bits 2-0 waveform, cell6, capture
// R15: reg11 bits 7-4 dma4, bit3 timer4
// R16: hardware set beats software clear
`ifndef IRQ_FLAG_DEFINES_SVH
`define IRQ_FLAG_DEFINES_SVH
`define ADDR_W          12
`define OFS_FLAGS_11    12'h4b9
`define OFS_FLAGS_12    12'h4ba
`define OFS_FLAGS_13    12'h4bb
`define OFS_FLAGS_14    12'h4bc
`define FLAGS_RESET     8'h00
`define STICKY_MASK_11  8'hff
`define STICKY_MASK_12  8'hf0
`define STICKY_MASK_13  8'hf0
`define STICKY_MASK_14  8'h0e
`define READ_ZERO       8'h00
`endif

//--- common/irq_flag_pkg.sv
// types for the peripheral request flag bank
`default_nettype none
package irq_flag_pkg;
    // one dma channel's four event sources, bit 3 is abort
    typedef struct packed {
        logic abort;
        logic overrun;
        logic dest_count;
        logic src_count;
    } dma_events_t;
    // uart state mirrored into the bank
    typedef struct packed {
        logic general_irq_pending;
        logic error_pending;
        logic tx_request;
        logic rx_request;
    } uart_status_t;
    typedef struct packed {
        logic       write;
        logic       read;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } reg_access_t;
endpackage : irq_flag_pkg
`default_nettype wire

//--- rtl/sticky_flag_bank.sv
// sticky hardware-set, software-clear flag byte
`timescale 1ns/1ps
`default_nettype none
`include "irq_flag_defines.svh"
module sticky_flag_bank #(
    parameter int          WIDTH = 8,
    parameter logic [7:0]  MASK  = 8'hff
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // hardware set events
    input  wire logic [WIDTH-1:0] set_event,
    // software write
    input  wire logic             wr,
    input  wire logic [WIDTH-1:0] wdata,
    // flag state
    output logic      [WIDTH-1:0] flags
);
    localparam logic [7:0] RESET_VALUE = `FLAGS_RESET;

    // the reset value and mask are byte wide, so other widths are refused
    if (WIDTH != 8) begin : g_width_check
        $error("sticky_flag_bank serves 8-bit registers only");
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            if (MASK[i]) begin : g_sticky
                always_ff @(posedge ref_clk or posedge rst) begin
                    if (rst) begin
                        flags[i] <= RESET_VALUE[i];
                    end else if (set_event[i]) begin
                        flags[i] <= 1'b1; // R1 R16
                    end else if (wr) begin
                        flags[i] <= wdata[i]; // R3
                    end
                end
            end else begin : g_none
                assign flags[i] = 1'b0;
            end
        end
    endgenerate
endmodule : sticky_flag_bank
`default_nettype wire

//--- tb/uart_model.sv
// behavioural uart side: general, error and tx/rx request state
`timescale 1ns/1ps
`default_nettype none
module uart_model
    import irq_flag_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [5:0] set_b,
    input  wire logic [5:0] clr_b,
    output var uart_status_t status
);
    logic [5:0] regs;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) regs <= 6'h00;
        else regs <= (regs | set_b) & ~clr_b;
    end
    // summary and error stay up until every bit of their register is clear
    assign status = {|regs[5:4], |regs[3:2], regs[1:0]};
endmodule : uart_model
`default_nettype wire

//--- tb/irq_flag_monitor.sv
// concurrent checks on the flag bank ports
`timescale 1ns/1ps
`default_nettype none
module irq_flag_monitor
    import irq_flag_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         rst,
    input wire logic [11:0]  addr,
    input wire logic         wr_strobe,
    input wire logic         rd_strobe,
    input wire logic [7:0]   rdata,
    input wire dma_events_t  dma_ch5_events,
    input wire dma_events_t  dma_ch6_events,
    input wire uart_status_t uart_four_status,
    input wire uart_status_t uart_five_status,
    input wire logic [7:0]   periph_irq_flags_12,
    input wire logic [7:0]   periph_irq_flags_13
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_rd_idle: assert property (!rd_strobe |=> rdata == 8'h00)
        else $error("rdata not zero");
    a_rd_unmapped: assert property (rd_strobe && (addr < 12'h4b9 || addr > 12'h4bc)
        |=> rdata == 8'h00) else $error("unmapped read not zero");
    a_rd_reg_twelve: assert property (rd_strobe && addr == 12'h4ba
        |=> rdata == $past(periph_irq_flags_12)) else $error("reg12 read wrong");
    a_uart4_mirror: assert property (!$past(rst)
        |-> periph_irq_flags_12[3:0] == $past(uart_four_status)) else $error("uart4 wrong");
    a_uart5_mirror: assert property (!$past(rst)
        |-> periph_irq_flags_13[3:0] == $past(uart_five_status)) else $error("uart5 wrong");
    a_dma5_set: assert property (dma_ch5_events != 4'h0 |=>
        (periph_irq_flags_12[7:4] & $past(dma_ch5_events)) == $past(dma_ch5_events))
        else $error("dma5 flag not set");
    a_dma6_set: assert property (dma_ch6_events != 4'h0 |=>
        (periph_irq_flags_13[7:4] & $past(dma_ch6_events)) == $past(dma_ch6_events))
        else $error("dma6 flag not set");
    a_sticky_hold: assert property (periph_irq_flags_12[7] && !(wr_strobe && addr == 12'h4ba)
        |=> periph_irq_flags_12[7]) else $error("sticky flag lost");
endmodule : irq_flag_monitor
`default_nettype wire

//--- tb/peripheral_irq_flag_regs_12_14_tb.sv
// self-checking bench for the peripheral request flag bank
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flag_regs_12_14_tb;
    import irq_flag_pkg::*;
    logic         ref_clk, rst, wr_strobe, rd_strobe;
    logic [11:0]  addr, a;
    logic [7:0]   wdata, rdata, e, x, got, f11, f12, f13, f14;
    dma_events_t  d4, d5, d6;
    logic [6:0]   ev;
    logic [5:0]   set_b [2];
    logic [5:0]   clr_b [2];
    uart_status_t us [2];
    int           n_fail = 0;
    int           n_tests = 0;
    logic [27:0]  rows [8] = '{28'h4b9ffff, 28'h4b9a5a5, 28'h4bafff0, 28'h4ba5050,
                               28'h4bbfff0, 28'h4bba0a0, 28'h4bcff0e, 28'h4bc0404};
    logic [31:0]  useq [4] = '{32'h3300040b, 32'h0020000b, 32'h0c100007, 32'h000c0003};
    periph_irq_flag_regs dut_u (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .dma_ch4_events(d4),
        .dma_ch5_events(d5), .dma_ch6_events(d6), .timer_four_event(ev[6]),
        .waveform_gen_three_event(ev[5]), .logic_cell_six_event(ev[4]),
        .capture_compare_three_event(ev[3]), .num_osc_three_event(ev[2]),
        .comparator_two_event(ev[1]), .logic_cell_seven_event(ev[0]),
        .uart_four_status(us[0]), .uart_five_status(us[1]), .periph_irq_flags_11(f11),
        .periph_irq_flags_12(f12), .periph_irq_flags_13(f13), .periph_irq_flags_14(f14));
    for (genvar u = 0; u < 2; u++) begin : g_uart
        uart_model m_u (.ref_clk(ref_clk), .rst(rst), .set_b(set_b[u]), .clr_b(clr_b[u]),
            .status(us[u]));
    end
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic step;
        @(posedge ref_clk);
        {wr_strobe, rd_strobe, d4, d5, d6, ev} <= '0;
        set_b <= '{6'h00, 6'h00};
        clr_b <= '{6'h00, 6'h00};
        @(posedge ref_clk);
    endtask : step
    task automatic wr(input logic [11:0] wa, input logic [7:0] wd);
        addr <= wa;
        wdata <= wd;
        wr_strobe <= 1'b1;
        step;
    endtask : wr
    task automatic rd(input logic [11:0] ra);
        addr <= ra;
        rd_strobe <= 1'b1;
        @(posedge ref_clk);
        rd_strobe <= 1'b0;
        #1 got = rdata;
        @(posedge ref_clk);
    endtask : rd
    task automatic chk(input string s, input logic [7:0] xv, input logic [7:0] gv);
        n_tests++;
        if (gv !== xv) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", s, xv, gv);
        end
    endtask : chk
    task automatic print_verdict;
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        rst = 1'b1;
        {wr_strobe, rd_strobe, addr, wdata, d4, d5, d6, ev} = '0;
        set_b = '{6'h00, 6'h00};
        clr_b = '{6'h00, 6'h00};
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            {a, e, x} = rows[i];
            case (a)
                12'h4b9: {d4, ev[6:3]} <= e;
                12'h4ba: d5 <= e[7:4];
                12'h4bb: d6 <= e[7:4];
                default: ev[2:0] <= e[3:1];
            endcase
            step;
            rd(a);
            chk("flags", x, got);
            wr(a, 8'h00);
            rd(a);
            chk("cleared", 8'h00, got);
        end
        for (int u = 0; u < 2; u++) begin
            for (int k = 0; k < 4; k++) begin
                set_b[u] <= useq[k][29:24];
                clr_b[u] <= useq[k][21:16];
                a = 12'h4ba + 12'(u);
                step;
                wr(a, useq[k][15:8]);
                rd(a);
                chk("uart", useq[k][7:0], got);
            end
        end
        d5 <= 4'h8;
        wr(12'h4ba, 8'h00);
        rd(12'h4ba);
        chk("set_wins", 8'h83, got);
        rd(12'h4bd);
        chk("unmapped", 8'h00, got);
        wr(12'h4bc, 8'hff);
        rd(12'h4bc);
        chk("reg14", 8'h0e, got);
        rst <= 1'b1;
        step;
        chk("rst11", 8'h00, f11);
        chk("rst12", 8'h00, f12);
        chk("rst13", 8'h00, f13);
        chk("rst14", 8'h00, f14);
        print_verdict;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_fail++;
        print_verdict;
    end
endmodule : peripheral_irq_flag_regs_12_14_tb
bind periph_irq_flag_regs irq_flag_monitor mon_u (.*);
`default_nettype wire
